// [testbench.sv]
// self-checking bench: bus master against a behavioural sensor slave
// assumes design, checker and sensor model are compiled before it

`timescale 1ns/1ns
`default_nettype none

module testbench
  import tsh_pkg::*;
;
  localparam int unsigned Q    = 8;
  localparam int unsigned FR   = 16;
  localparam logic [2:0]  PINS = 3'h5;

  logic       sys_clk_i;
  logic       rst_n_i;
  logic       ce_i;
  logic       req_valid_i;
  tsh_req_t   req_i;
  logic       req_ready_o;
  tsh_rsp_t   rsp_o;
  logic       scl_o;
  logic       scl_oe_o;
  logic       sda_o;
  logic       sda_oe_o;
  logic       sda_oe_s;
  logic [7:0] viol;
  wire logic  scl_w;
  wire logic  sda_w;
  int         n_errors;
  int         checked;

  // open-drain wires with pull-ups: low while any party drives
  assign scl_w = ~(scl_oe_o & ~scl_o);
  assign sda_w = ~((sda_oe_o & ~sda_o) | sda_oe_s);

  // short quarter and free counts keep the run brief
  tsh_master #(.QCYC(Q), .FREE_CYC(FR)) dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rsp_o(rsp_o), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
  tsh_sensor_model #(.PINS(PINS), .FREE_NS(FR * SYS_CLK_NS)) sensor (
    .scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(sda_oe_s), .viol_o(viol));

  // 125 MHz system clock
  always #4 sys_clk_i = ~sys_clk_i;

  task automatic close_out();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // count a comparison and report a miss at once
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // one command: wait for ready, hold valid over the taking edge, await done
  task automatic issue(input tsh_cmd_t k, input logic [2:0] s,
                       input logic [3:0] p, input logic [15:0] w,
                       input logic frz = 1'b0);
    int n;
    logic s_c;
    logic s_d;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 5000) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    req_valid_i = 1'b1;
    req_i = '{kind: k, addr_sel: s, ptr: p, wdata: w};
    @(posedge sys_clk_i);
    #1;
    req_valid_i = 1'b0;
    if (frz) begin
      // a low enable mid-byte must freeze the pins and the sequence
      repeat (100) @(posedge sys_clk_i);
      #1;
      ce_i = 1'b0;
      s_c = scl_oe_o;
      s_d = sda_oe_o;
      repeat (20) @(posedge sys_clk_i);
      #1;
      chk(scl_oe_o === s_c && sda_oe_o === s_d && rsp_o.done === 1'b0,
          "state moved while disabled");
      ce_i = 1'b1;
    end
    while (rsp_o.done !== 1'b1 && n < 5000) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n >= 5000) begin
      chk(1'b0, "command never finished");
      close_out();
    end
  endtask

  // pointer is held and never stepped; data comes high byte first
  task automatic t_write_read();
    issue(TSH_CMD_WRITE, PINS, 4'h3, 16'hc3a5);
    chk(rsp_o.nak === 1'b0, "write not acknowledged");
    issue(TSH_CMD_WRITE, PINS, 4'h4, 16'h5a17, 1'b1);
    issue(TSH_CMD_SET_PTR, PINS, 4'h3, 16'h0);
    issue(TSH_CMD_READ, PINS, 4'h0, 16'h0);
    chk(rsp_o.rdata === 16'hc3a5, "read after pointer set");
    issue(TSH_CMD_READ, PINS, 4'h0, 16'h0);
    chk(rsp_o.rdata === 16'hc3a5, "repeat read moved on");
    issue(TSH_CMD_SET_PTR, PINS, 4'h4, 16'h0);
    issue(TSH_CMD_READ, PINS, 4'h0, 16'h0);
    chk(rsp_o.rdata === 16'h5a17, "second register wrong");
  endtask
  // a request during the free time is ignored and changes nothing
  task automatic t_refused();
    req_valid_i = 1'b1;
    req_i = '{kind: TSH_CMD_WRITE, addr_sel: PINS, ptr: 4'h4, wdata: 16'hffff};
    repeat (8) @(posedge sys_clk_i);
    #1;
    chk(req_ready_o === 1'b0, "ready during free time");
    req_valid_i = 1'b0;
    issue(TSH_CMD_READ, PINS, 4'h0, 16'h0);
    chk(rsp_o.rdata === 16'h5a17, "refused write took effect");
  endtask
  // every address selection: only the pin-selected one answers
  task automatic t_addr_scan();
    for (int s = 0; s < 8; s++) begin
      issue(TSH_CMD_READ, 3'(s), 4'h0, 16'h0);
      chk(rsp_o.nak === (3'(s) != PINS), "address answer");
    end
  endtask

  // reset, scenarios, then the fault count kept by the sensor
  initial begin
    sys_clk_i   = 1'b0;
    rst_n_i     = 1'b0;
    ce_i        = 1'b1;
    req_valid_i = 1'b0;
    req_i       = '0;
    n_errors    = 0;
    checked     = 0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk(!req_ready_o && !scl_oe_o && !sda_oe_o, "reset state");
    rst_n_i = 1'b1;
    t_write_read();
    t_refused();
    t_addr_scan();
    chk(viol === 8'h0, "sensor saw a bus fault");
    close_out();
  end
endmodule

`default_nettype wire

// [tsh_bit.sv]
// bit-level engine: drives clock and data pins for one condition or bit
// assumes pins are open drain with external pull-ups; inputs pass two sync flops

`timescale 1ns/1ns
`default_nettype none

module tsh_bit
  import tsh_pkg::*;
#(
  parameter int unsigned QCYC = QUARTER_CYC
) (
  // clock and control
  input  wire logic    sys_clk_i,
  input  wire logic    rst_n_i,
  input  wire logic    ce_i,
  // operation request
  input  wire logic    go_i,
  input  wire tsh_op_t op_i,
  input  wire logic    bit_i,
  output logic         busy_o,
  output logic         done_o,
  output logic         bit_o,
  // bus pins
  input  wire logic    scl_i,
  input  wire logic    sda_i,
  output logic         scl_oe_o,
  output logic         sda_oe_o
);

  initial begin
    if (QCYC < 1) $error("tsh_bit: QCYC must be at least one");
  end

  typedef struct packed {
    logic [1:0]  scl_sy;
    logic [1:0]  sda_sy;
    logic        busy;
    logic        done;
    logic        rbit;
    logic [1:0]  phase;
    logic [15:0] cnt;
    tsh_op_t     op;
    logic        wbit;
    logic        scl_oe;
    logic        sda_oe;
  } tsh_bit_st_t;

  tsh_bit_st_t st_reg, st_next;

  // four phases per op, each a quarter period; scl low in 0/1 for bits
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.scl_sy = {st_reg.scl_sy[0], scl_i};
    st_next.sda_sy = {st_reg.sda_sy[0], sda_i};
    if (!st_reg.busy) begin
      if (go_i) begin
        st_next.busy  = 1'b1;
        st_next.op    = op_i;
        st_next.wbit  = bit_i;
        st_next.phase = 2'h0;
        st_next.cnt   = 16'(QCYC);
      end
    end else if (st_reg.cnt > 16'h1) begin
      // clock high phase 2 of a bit stretches while the pin is still seen low
      if (!(st_reg.phase == 2'h2 && !st_reg.scl_sy[1] &&
            (st_reg.op == TSH_OP_WBIT || st_reg.op == TSH_OP_RBIT)))
        st_next.cnt = st_reg.cnt - 16'h1;
    end else begin
      st_next.cnt   = 16'(QCYC);
      st_next.phase = st_reg.phase + 2'h1;
      case (st_reg.op)
        TSH_OP_START: begin
          // data falls while clock is high, then clock goes low
          case (st_reg.phase)
            2'h0: begin st_next.sda_oe = 1'b0; st_next.scl_oe = 1'b0; end
            2'h1: st_next.sda_oe = 1'b1;
            2'h2: st_next.scl_oe = 1'b1;
            default: ;
          endcase
        end
        TSH_OP_STOP: begin
          // data rises while clock is high
          case (st_reg.phase)
            2'h0: st_next.sda_oe = 1'b1;
            2'h1: st_next.scl_oe = 1'b0;
            2'h2: st_next.sda_oe = 1'b0;
            default: ;
          endcase
        end
        default: begin
          // data changes only in clock-low phase 0
          case (st_reg.phase)
            2'h0: st_next.sda_oe = (st_reg.op == TSH_OP_WBIT) ?
                                   !st_reg.wbit : 1'b0;
            2'h1: st_next.scl_oe = 1'b0;
            2'h2: st_next.rbit   = st_reg.sda_sy[1];
            2'h3: st_next.scl_oe = 1'b1;
            default: ;
          endcase
        end
      endcase
      if (st_reg.phase == 2'h3) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end

  // state register; clock is released at reset so the bus stays idle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.op <= TSH_OP_STOP;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign busy_o   = st_reg.busy;
  assign done_o   = st_reg.done;
  assign bit_o    = st_reg.rbit;
  assign scl_oe_o = st_reg.scl_oe;
  assign sda_oe_o = st_reg.sda_oe;

endmodule

`default_nettype wire

// [tsh_master.sv]
// bus master for the temperature sensor serial port: one command per access
// assumes open-drain pins with pull-ups resolved by the surroundings
//
// Operation
// - eighth address bit: one reads, zero writes
// - every access begins with a falling data edge while clock is high
// - every access ends with a rising data edge while clock is high
// - each access is closed with a stop before another begins
// - after a stop, wait the bus free time before the next start
// - data changes only while the clock is low
// - the slave acknowledges every byte it receives
// - the master supplies a ninth clock for the acknowledge
// - acknowledge is held low across the whole ninth clock pulse
// - master does not acknowledge the last read byte
// - pointer byte uses low four bits; upper four written zero

`timescale 1ns/1ns
`default_nettype none

module tsh_master
  import tsh_pkg::*;
#(
  parameter int unsigned QCYC      = QUARTER_CYC,
  parameter int unsigned FREE_CYC  = BUS_FREE_CYC
) (
  // clock, reset, enable
  input  wire logic     sys_clk_i,
  input  wire logic     rst_n_i,
  input  wire logic     ce_i,
  // user command
  input  wire logic     req_valid_i,
  input  wire tsh_req_t req_i,
  output logic          req_ready_o,
  output tsh_rsp_t      rsp_o,
  // bus pins
  input  wire logic     scl_i,
  input  wire logic     sda_i,
  output logic          scl_o,
  output logic          scl_oe_o,
  output logic          sda_o,
  output logic          sda_oe_o
);

  initial begin
    if (FREE_CYC < 1) $error("tsh_master: FREE_CYC must be at least one");
  end

  // one bit changes per step from idle to free; next to byte, ack to stop and free to idle change two
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_START = 4'b0001,
    ST_BYTE  = 4'b0011,
    ST_ACK   = 4'b0010,
    ST_NEXT  = 4'b0110,
    ST_STOP  = 4'b0111,
    ST_FREE  = 4'b0101
  } tsh_state_t;

  typedef struct packed {
    tsh_state_t  state;
    tsh_req_t    req;
    logic [1:0]  idx;      // byte index within access
    logic [3:0]  nbit;
    logic [7:0]  sh;
    logic [15:0] rdata;
    logic        nak;
    logic        go;
    tsh_op_t     op;
    logic        wbit;
    logic [15:0] free_cnt;
    logic        ready;
    tsh_rsp_t    rsp;
  } tsh_st_t;

  tsh_st_t st_reg, st_next;

  logic busy_w;
  logic done_w;
  logic rbit_w;
  logic scl_oe_w;
  logic sda_oe_w;
  logic is_read;
  logic [1:0] last_idx;
  logic [1:0] tx_idx;
  logic [7:0] tx_byte;

  // bit engine; the master alone drives the clock pin
  tsh_bit #(
    .QCYC (QCYC)
  ) u_bit (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .go_i      (st_reg.go),
    .op_i      (st_reg.op),
    .bit_i     (st_reg.wbit),
    .busy_o    (busy_w),
    .done_o    (done_w),
    .bit_o     (rbit_w),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .scl_oe_o  (scl_oe_w),
    .sda_oe_o  (sda_oe_w)
  );

  // byte plan for the held command
  always_comb begin
    is_read = (st_reg.req.kind == TSH_CMD_READ);
    // the next state loads the following byte, so look one index ahead
    tx_idx = (st_reg.state == ST_NEXT) ? st_reg.idx + 2'h1 : st_reg.idx;
    case (st_reg.req.kind)
      TSH_CMD_SET_PTR: last_idx = 2'h1;
      TSH_CMD_WRITE:   last_idx = 2'h3;
      default:         last_idx = 2'h2;
    endcase
    case (tx_idx)
      2'h0: tx_byte = {SENSOR_ADDR_HI, st_reg.req.addr_sel,
                       is_read ? DIR_READ : DIR_WRITE};
      2'h1: tx_byte = {PTR_HI_ZERO, st_reg.req.ptr};
      2'h2: tx_byte = st_reg.req.wdata[15:8];
      default: tx_byte = st_reg.req.wdata[7:0];
    endcase
  end

  // access sequencer
  always_comb begin
    st_next = st_reg;
    st_next.go = 1'b0;
    st_next.rsp.done = 1'b0;
    case (st_reg.state)
      ST_IDLE: begin
        // start only from an idle bus, both lines released
        if (req_valid_i && st_reg.ready) begin
          st_next.req   = req_i;
          st_next.ready = 1'b0;
          st_next.idx   = 2'h0;
          st_next.nak   = 1'b0;
          st_next.op    = TSH_OP_START;
          st_next.go    = 1'b1;
          st_next.state = ST_START;
        end else if (!st_reg.ready && !busy_w) begin
          // ready comes up once the engine is quiet after reset
          st_next.ready = 1'b1;
        end
      end
      ST_START: begin
        if (done_w) begin
          st_next.sh    = tx_byte;
          st_next.nbit  = 4'h0;
          st_next.state = ST_BYTE;
        end
      end
      ST_BYTE: begin
        // issue one bit when the engine is free, msb first
        // not in the done cycle: the shift register is still the old bit
        if (!busy_w && !st_reg.go && !done_w) begin
          st_next.go   = 1'b1;
          st_next.op   = (is_read && st_reg.idx != 2'h0) ?
                         TSH_OP_RBIT : TSH_OP_WBIT;
          st_next.wbit = st_reg.sh[BYTE_W-1];
        end
        if (done_w) begin
          st_next.sh = {st_reg.sh[BYTE_W-2:0], rbit_w};
          if (st_reg.nbit == BIT_LAST) begin
            // ninth clock for the acknowledge
            st_next.go = 1'b1;
            if (is_read && st_reg.idx != 2'h0) begin
              st_next.op   = TSH_OP_WBIT;
              // low ack except on the last byte
              st_next.wbit = (st_reg.idx == last_idx);
            end else begin
              st_next.op   = TSH_OP_RBIT;
              st_next.wbit = 1'b1;
            end
            st_next.state = ST_ACK;
          end else begin
            st_next.nbit = st_reg.nbit + 4'h1;
          end
        end
      end
      ST_ACK: begin
        if (done_w) begin
          if (is_read && st_reg.idx != 2'h0) begin
            st_next.rdata = {st_reg.rdata[7:0], st_reg.sh};
            st_next.state = ST_NEXT;
          end else if (rbit_w) begin
            // slave did not answer: close with a stop
            st_next.nak   = 1'b1;
            st_next.op    = TSH_OP_STOP;
            st_next.go    = 1'b1;
            st_next.state = ST_STOP;
          end else begin
            st_next.state = ST_NEXT;
          end
        end
      end
      ST_NEXT: begin
        if (st_reg.idx == last_idx) begin
          st_next.op    = TSH_OP_STOP;
          st_next.go    = 1'b1;
          st_next.state = ST_STOP;
        end else begin
          // read after address only returns the held pointer
          st_next.idx   = (is_read && st_reg.idx == 2'h0) ? 2'h1 :
                          st_reg.idx + 2'h1;
          st_next.sh    = tx_byte;
          st_next.nbit  = 4'h0;
          st_next.state = ST_BYTE;
          if (is_read && st_reg.idx == 2'h0)
            st_next.idx = 2'h1;
        end
      end
      ST_STOP: begin
        if (done_w) begin
          st_next.free_cnt  = 16'(FREE_CYC);
          st_next.rsp.done  = 1'b1;
          st_next.rsp.nak   = st_reg.nak;
          st_next.rsp.rdata = st_reg.rdata;
          st_next.state     = ST_FREE;
        end
      end
      ST_FREE: begin
        // bus free time before any new start
        if (st_reg.free_cnt > 16'h1)
          st_next.free_cnt = st_reg.free_cnt - 16'h1;
        else begin
          st_next.ready = 1'b1;
          st_next.state = ST_IDLE;
        end
      end
      default: st_next.state = ST_IDLE;
    endcase
  end

  // state register; ready comes up one cycle after reset
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_reg       <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.op    <= TSH_OP_STOP;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // pin outputs are flops in the engine; drive level is always low
  assign req_ready_o = st_reg.ready;
  assign rsp_o       = st_reg.rsp;
  assign scl_o       = 1'b0;
  assign sda_o       = 1'b0;
  assign scl_oe_o    = scl_oe_w;
  assign sda_oe_o    = sda_oe_w;

endmodule

`default_nettype wire

// [tsh_master_props.sv]
// checker for the temperature sensor bus master, on its top ports only
// assumes open-drain pins and is bound into every tsh_master instance

`timescale 1ns/1ns
`default_nettype none

module tsh_master_props
  import tsh_pkg::*;
#(
  parameter int unsigned QCYC     = QUARTER_CYC,
  parameter int unsigned FREE_CYC = BUS_FREE_CYC
) (
  // clock and reset
  input  wire logic     sys_clk_i,
  input  wire logic     rst_n_i,
  // user side
  input  wire logic     req_valid_i,
  input  wire logic     req_ready_o,
  input  wire tsh_rsp_t rsp_o,
  // bus pins
  input  wire logic     scl_o,
  input  wire logic     scl_oe_o,
  input  wire logic     sda_o,
  input  wire logic     sda_oe_o
);
  logic [15:0] free_cnt_reg;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // cycles since the last done; saturates so a long idle never wraps
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      free_cnt_reg <= 16'h0;
    end else if (rsp_o.done) begin
      free_cnt_reg <= 16'h1;
    end else if (free_cnt_reg != 16'h0 && free_cnt_reg != 16'hffff) begin
      free_cnt_reg <= free_cnt_reg + 16'h1;
    end
  end

  a_take_drop:
    assert property (req_valid_i && req_ready_o |=> !req_ready_o)
    else $error("ready stayed high after a take");
  a_start_first:
    assert property (req_valid_i && req_ready_o |=>
      !scl_oe_o throughout (##[1:40] $rose(sda_oe_o)))
    else $error("access did not open with a start");
  a_start_hold:
    assert property ($rose(sda_oe_o) && !scl_oe_o |->
      sda_oe_o throughout (##[1:40] scl_oe_o))
    else $error("start not held until clock pulled low");
  a_stop_done:
    assert property ($fell(sda_oe_o) && !scl_oe_o |->
      !scl_oe_o throughout (##[0:40] rsp_o.done))
    else $error("data moved while clock high outside a stop");
  a_free_wait:
    assert property (free_cnt_reg != 16'h0 && free_cnt_reg < FREE_CYC |->
      !req_ready_o && !scl_oe_o && !sda_oe_o)
    else $error("bus not left idle for the free time");
  a_ready_back:
    assert property (rsp_o.done |-> ##[1:40] req_ready_o)
    else $error("ready did not return after the free time");
  a_idle_ready:
    assert property (req_ready_o |-> !scl_oe_o && !sda_oe_o)
    else $error("pins driven while ready");
  a_done_pulse:
    assert property (rsp_o.done |=> !rsp_o.done)
    else $error("done longer than one cycle");
  a_scl_high:
    assert property ($fell(scl_oe_o) |-> (!scl_oe_o) [*8])
    else $error("clock high phase too short");
  a_scl_low:
    assert property ($rose(scl_oe_o) |-> scl_oe_o [*6])
    else $error("clock low phase too short");
  a_open_drain:
    assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin drive level not low");
endmodule

bind tsh_master tsh_master_props #(.QCYC(QCYC), .FREE_CYC(FREE_CYC)) u_props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .rsp_o(rsp_o), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

`default_nettype wire

// [tsh_pkg.sv]
// package for the temperature sensor bus master: constants, command and operation kinds, carriers
// assumes a 125 MHz system clock; no other files are needed

package tsh_pkg;

  // clock and bus timing, times in ns
  localparam int unsigned SYS_CLK_NS       = 8;
  localparam int unsigned T_LOW_NS         = 4700;
  localparam int unsigned T_HIGH_NS        = 4000;
  localparam int unsigned T_BUS_FREE_NS    = 4700;
  localparam int unsigned T_SU_STA_NS      = 4700;
  localparam int unsigned T_HD_STA_NS      = 4000;
  localparam int unsigned T_SU_STO_NS      = 4000;
  // least times round up to whole cycles
  localparam int unsigned QUARTER_NS       = (T_LOW_NS + 1) / 2;
  localparam int unsigned QUARTER_CYC      =
    (QUARTER_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int unsigned BUS_FREE_CYC     =
    (T_BUS_FREE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // address layout
  localparam logic [3:0] SENSOR_ADDR_HI    = 4'h3;
  localparam logic       DIR_READ          = 1'b1;
  localparam logic       DIR_WRITE         = 1'b0;
  localparam logic [3:0] PTR_HI_ZERO       = 4'h0;
  localparam int unsigned BYTE_W           = 8;
  localparam logic [3:0] BIT_LAST          = 4'h7;

  // command kinds from the user side
  typedef enum logic [1:0] {
    TSH_CMD_SET_PTR = 2'h0,   // pointer only
    TSH_CMD_WRITE   = 2'h1,   // pointer then two data bytes
    TSH_CMD_READ    = 2'h2    // read two bytes from last pointer
  } tsh_cmd_t;

  typedef struct packed {
    tsh_cmd_t    kind;
    logic [2:0]  addr_sel;
    logic [3:0]  ptr;
    logic [15:0] wdata;
  } tsh_req_t;

  typedef struct packed {
    logic        done;
    logic        nak;
    logic [15:0] rdata;
  } tsh_rsp_t;

  // bit engine operations
  typedef enum logic [2:0] {
    TSH_OP_START = 3'h0,
    TSH_OP_STOP  = 3'h1,
    TSH_OP_WBIT  = 3'h2,
    TSH_OP_RBIT  = 3'h3
  } tsh_op_t;

endpackage

// [tsh_sensor_model.sv]
// behavioural temperature sensor slave port on a pulled-up two-wire bus
// assumes resolved wire levels at its inputs; it never drives the clock

`timescale 1ns/1ns
`default_nettype none

module tsh_sensor_model #(
  parameter logic [2:0] PINS    = 3'h5,
  parameter int         FREE_NS = 128,
  parameter int         BUS_IDLE_TIMEOUT_NS = 30000000
) (
  // resolved wire levels; no clock output at all
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  // data pull-down and count of master protocol faults
  output logic       sda_oe_o,
  output logic [7:0] viol_o
);
  logic [15:0] regs [16];
  logic [3:0]  ptr;
  logic [7:0]  b;
  logic [7:0]  hi;
  logic        m;
  logic        act;
  time         stop_t;
  time         scl_t;
  event        go;

  // power-up state
  initial begin
    regs     = '{default: 16'h0};
    sda_oe_o = 1'b0;
    viol_o   = 8'h0;
    ptr      = 4'h0;
    act      = 1'b0;
    stop_t   = 0;
    scl_t    = 0;
  end

  // bus idle timeout: a clock stuck either way drops the access
  always @(scl_i) scl_t = $time;
  always begin
    #(BUS_IDLE_TIMEOUT_NS / 4);
    if (act && $time - scl_t >= BUS_IDLE_TIMEOUT_NS) begin
      disable xfer;
      sda_oe_o = 1'b0;
      act = 1'b0;
    end
  end

  // shift in one byte on rising clock edges
  task automatic rx(output logic [7:0] v);
    repeat (8) begin
      @(posedge scl_i);
      v = {v[6:0], sda_i};
    end
  endtask
  // hold data low across the whole ninth clock
  task automatic ack();
    @(negedge scl_i);
    #20 sda_oe_o = 1'b1;
    @(negedge scl_i);
    #20 sda_oe_o = 1'b0;
  endtask
  // shift a byte out while clock is low, then sample the master's answer
  task automatic tx(input logic [7:0] v, output logic a);
    for (int i = 7; i >= 0; i--) begin
      sda_oe_o = ~v[i];
      @(negedge scl_i);
      #20;
    end
    sda_oe_o = 1'b0;
    @(posedge scl_i);
    a = sda_i;
    @(negedge scl_i);
    #20;
  endtask

  // one access after a start; a start or stop kills it midway
  always begin : xfer
    @(go);
    rx(b);
    if (b[7:1] == {4'h3, PINS}) begin
      ack();
      if (b[0]) begin
        tx(regs[ptr][15:8], m);
        viol_o = viol_o + {7'h0, m};
        tx(regs[ptr][7:0], m);
        viol_o = viol_o + {7'h0, !m};
      end else begin
        rx(b);
        ack();
        viol_o = viol_o + {7'h0, b[7:4] != 4'h0};
        ptr = b[3:0];
        rx(hi);
        ack();
        rx(b);
        ack();
        regs[ptr] = {hi, b};
      end
    end
  end

  // start: a start on a busy bus lacks its stop, or came too soon
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      if (act || (stop_t != 0 && $time - stop_t < FREE_NS)) begin
        viol_o = viol_o + 8'h1;
      end
      disable xfer;
      sda_oe_o = 1'b0;
      act = 1'b1;
      #1 -> go;
    end
  end
  // stop: drop the access and leave the line to the pull-up
  always @(posedge sda_i) begin
    if (scl_i === 1'b1) begin
      disable xfer;
      sda_oe_o = 1'b0;
      act = 1'b0;
      stop_t = $time;
    end
  end
endmodule

`default_nettype wire
